// file: common/fdcrv_cnt_if.sv
// Interface between sequencer and sector byte counter
`timescale 1ns/1ps
interface fdcrv_cnt_if;
  logic       start;
  logic [7:0] size_code;
  logic [7:0] data_len;
  logic       stb;
  logic       last;
  modport ctl (output start, size_code, data_len, stb, input last);
  modport cnt (input start, size_code, data_len, stb, output last);
endinterface : fdcrv_cnt_if

// file: common/fdcrv_pkg.sv
// Package with opcodes, field positions, status codes and states
package fdcrv_pkg;
  localparam logic [4:0] OP_READ_TRACK = 5'h02;
  localparam logic [4:0] OP_READ_ID    = 5'h0a;
  localparam logic [4:0] OP_VERIFY     = 5'h16;
  localparam logic [4:0] OP_WRITE      = 5'h05;
  localparam int         BIT_MULTI     = 7;
  localparam int         BIT_DENSITY   = 6;
  localparam int         BIT_SKIP      = 5;
  localparam int         BIT_COUNT_EN  = 7;
  localparam int         BIT_HEAD      = 2;
  localparam logic [3:0] LAST_BYTE_ID  = 4'h1;
  localparam logic [3:0] LAST_BYTE_RW  = 4'h8;
  localparam logic [2:0] RES_LEN       = 3'h7;
  localparam logic [2:0] RES_LEN_BAD   = 3'h1;
  localparam logic [1:0] IDX_LIMIT     = 2'h2;
  localparam int         P_C           = 0;
  localparam int         P_H           = 1;
  localparam int         P_R           = 2;
  localparam int         P_N           = 3;
  localparam int         P_EOT         = 4;
  localparam int         P_DTL         = 6;
  localparam int         NUM_PAR       = 7;
  localparam logic [1:0] IC_NORMAL     = 2'h0;
  localparam logic [1:0] IC_ABNORMAL   = 2'h1;
  localparam logic [1:0] IC_INVALID    = 2'h2;
  localparam logic [7:0] ST1_NO_DATA   = 8'h04;
  localparam logic [7:0] ST1_MISS_AM   = 8'h01;
  localparam logic [7:0] ST1_CRC_ERR   = 8'h20;
  localparam logic [7:0] ST2_DEL_MARK  = 8'h40;
  localparam logic [14:0] BYTES_N0     = 15'h0080;
  localparam logic [2:0] MAX_SIZE_CODE = 3'h7;
  localparam int         PIN_W         = 45;

  typedef enum logic [2:0] {
    FDCRV_IDLE   = 3'b000,
    FDCRV_CMD    = 3'b001,
    FDCRV_SEEK   = 3'b010,
    FDCRV_XFER   = 3'b011,
    FDCRV_RESULT = 3'b100
  } fdcrv_state_t;
endpackage : fdcrv_pkg

// file: hw/fdcrv_byte_counter.sv
// Sector byte counter sized by the size code
`timescale 1ns/1ps
module fdcrv_byte_counter
  import fdcrv_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  fdcrv_cnt_if.cnt  cnt_if
);
  logic [14:0] cnt_q;
  logic [14:0] cnt_d;
  logic [14:0] limit;
  logic [2:0]  code;

  always_comb
  begin
    // Codes above the largest supported size are clamped
    code  = (cnt_if.size_code > 8'(MAX_SIZE_CODE)) ? MAX_SIZE_CODE
                                                   : cnt_if.size_code[2:0];
    // Size code zero takes its length from the data length byte
    limit = (cnt_if.size_code == 8'h00) ? {7'h00, cnt_if.data_len}
                                        : (BYTES_N0 << code); // [RULE11]
    cnt_d = cnt_q;
    if (cnt_if.start)
      cnt_d = 15'h0000;
    else if (cnt_if.stb)
      cnt_d = cnt_q + 15'h0001;
    cnt_if.last = cnt_if.stb && (cnt_q + 15'h0001 >= limit);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
      cnt_q <= 15'h0000;
    else
      cnt_q <= cnt_d;
  end
endmodule : fdcrv_byte_counter

// file: hw/fdcrv_top.sv
// Command sequencer for track read, ID read, verify and write
//
// Behaviour
// [RULE1] Track read: opcode 00010, density D6, select byte, seven parameters; the code rejects it unless D7 D6 D5 are all clear.
// [RULE2] Track read sends every sector from index up to last sector number.
// [RULE3] Track read returns three status bytes then C, H, R, N.
// [RULE4] ID read: opcode 01010 plus select byte; first good ID is kept.
// [RULE5] ID read returns three status bytes then C, H, R, N found.
// [RULE6] Verify: flags D7 D6 D5, opcode 10110, count enable in byte two.
// [RULE7] Verify checks sectors and moves no data to or from the host.
// [RULE8] Verify returns three status bytes then C, H, R, N reached.
// [RULE9] Write: opcode 00101, D5 clear, host data to drive, seven results.
// [RULE10] Skip-deleted flag passes over sectors with deleted data marks.
// [RULE11] Size code sets bytes per sector for reads and writes.
// [RULE12] Verify last byte is sector count with count enable, else length.
// [RULE13] Host writes all command bytes, then reads all results.
`timescale 1ns/1ps
module fdcrv_top
  import fdcrv_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       cmd_wr_i,
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       res_rd_i,
  input  wire logic       host_byte_valid_i,
  input  wire logic [7:0] host_byte_i,
  input  wire logic       index_pin_i,
  input  wire logic       id_stb_pin_i,
  input  wire logic       id_crc_ok_pin_i,
  input  wire logic       id_deleted_pin_i,
  input  wire logic [7:0] id_c_pin_i,
  input  wire logic [7:0] id_h_pin_i,
  input  wire logic [7:0] id_r_pin_i,
  input  wire logic [7:0] id_n_pin_i,
  input  wire logic       rd_stb_pin_i,
  input  wire logic [7:0] rd_byte_pin_i,
  output logic            busy_o,
  output logic            res_valid_o,
  output logic [7:0]      res_data_o,
  output logic            host_byte_valid_o,
  output logic [7:0]      host_byte_o,
  output logic            data_req_o,
  output logic            disk_byte_valid_o,
  output logic [7:0]      disk_byte_o,
  output logic [1:0]      drive_sel_o,
  output logic            head_sel_o,
  output logic            density_o
);
  fdcrv_cnt_if cnt_if ();

  fdcrv_byte_counter u_cnt (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .cnt_if     (cnt_if)
  );

  // Drive pins are asynchronous: two stages, then a third for edges
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1_q;
  logic [PIN_W-1:0] pin_s2_q;
  logic [2:0]       stb_s3_q;
  assign pin_raw = {index_pin_i, id_stb_pin_i, rd_stb_pin_i, id_crc_ok_pin_i,
                    id_deleted_pin_i, id_c_pin_i, id_h_pin_i, id_r_pin_i,
                    id_n_pin_i, rd_byte_pin_i};

  // Not reset: stages fill with the live pin level during reset, so a
  // strobe already high at release does not look like a fresh edge
  always_ff @(posedge core_clk_i)
  begin
    pin_s1_q <= pin_raw;
    pin_s2_q <= pin_s1_q;
    stb_s3_q <= pin_s2_q[44:42];
  end

  logic       idx_e;
  logic       id_e;
  logic       rd_e;
  logic       id_ok;
  logic       id_del;
  logic [7:0] id_c;
  logic [7:0] id_h;
  logic [7:0] id_r;
  logic [7:0] id_n;
  logic [7:0] rd_byte;
  assign idx_e   = pin_s2_q[44] && !stb_s3_q[2];
  assign id_e    = pin_s2_q[43] && !stb_s3_q[1];
  assign rd_e    = pin_s2_q[42] && !stb_s3_q[0];
  assign id_ok   = pin_s2_q[41];
  assign id_del  = pin_s2_q[40];
  assign id_c    = pin_s2_q[39:32];
  assign id_h    = pin_s2_q[31:24];
  assign id_r    = pin_s2_q[23:16];
  assign id_n    = pin_s2_q[15:8];
  assign rd_byte = pin_s2_q[7:0];

  fdcrv_state_t st_q, st_d;
  logic [4:0] op_q, op_d;
  logic       mt_q, mt_d, sk_q, sk_d, ec_q, ec_d, mfm_q, mfm_d;
  logic       hds_q, hds_d, seen_q, seen_d;
  logic [1:0] ds_q, ds_d, idx_q, idx_d;
  logic [3:0] pcnt_q, pcnt_d, plast_q, plast_d;
  logic [2:0] ptr_q, ptr_d, rlen_q, rlen_d;
  logic [7:0] par_q [NUM_PAR];
  logic [7:0] par_d [NUM_PAR];
  logic [7:0] st0_q, st0_d, st1_q, st1_d, st2_q, st2_d;
  logic [7:0] scnt_q, scnt_d, res_q, res_d, hb_q, hb_d, db_q, db_d;
  logic       hv_q, hv_d, dv_q, dv_d, req_q, req_d;
  logic       adv, fail, done, is_rd;
  logic [7:0] cmd_sel;

  function automatic logic [7:0] mk_st0(input logic [1:0] ic,
                                        input logic hd,
                                        input logic [1:0] ds);
    mk_st0 = {ic, 3'h0, hd, ds};
  endfunction : mk_st0

  assign cnt_if.size_code = par_q[P_N];
  // Count enable turns the last byte into a sector count instead
  assign cnt_if.data_len  = (op_q == OP_VERIFY && ec_q) ? 8'h00
                                                        : par_q[P_DTL]; // [RULE12]
  assign cnt_if.stb       = (st_q == FDCRV_XFER) &&
                            (is_rd ? rd_e : (host_byte_valid_i && req_q));
  assign is_rd            = (op_q != OP_WRITE);
  assign cmd_sel          = cmd_byte_i;

  always_comb
  begin
    st_d = st_q; op_d = op_q; mt_d = mt_q; sk_d = sk_q; ec_d = ec_q;
    mfm_d = mfm_q; hds_d = hds_q; ds_d = ds_q; seen_d = seen_q;
    idx_d = idx_q; pcnt_d = pcnt_q; plast_d = plast_q; ptr_d = ptr_q;
    rlen_d = rlen_q; par_d = par_q; st0_d = st0_q; st1_d = st1_q;
    st2_d = st2_q; scnt_d = scnt_q; hb_d = hb_q; db_d = db_q;
    hv_d = 1'b0; dv_d = 1'b0; req_d = 1'b0;
    adv = 1'b0; fail = 1'b0; done = 1'b0;
    cnt_if.start = 1'b0;
    case (st_q)
      FDCRV_IDLE:
        if (cmd_wr_i)
        begin
          op_d  = cmd_sel[4:0];
          mfm_d = cmd_sel[BIT_DENSITY];
          mt_d  = cmd_sel[BIT_MULTI];
          sk_d  = cmd_sel[BIT_SKIP];
          pcnt_d = 4'h1;
          st1_d = 8'h00; st2_d = 8'h00; ptr_d = 3'h0;
          if ((cmd_sel[4:0] == OP_READ_TRACK && cmd_sel[7:5] == 3'h0 ) ||
              (cmd_sel[4:0] == OP_READ_ID && cmd_sel[7] == 1'b0) ||
              (cmd_sel[4:0] == OP_WRITE && !cmd_sel[BIT_SKIP]) ||
              cmd_sel[4:0] == OP_VERIFY) // [RULE1] [RULE4] [RULE6] [RULE9]
          begin
            plast_d = (cmd_sel[4:0] == OP_READ_ID) ? LAST_BYTE_ID
                                                   : LAST_BYTE_RW;
            st_d = FDCRV_CMD;
          end
          else
          begin
            // Unknown codes and disallowed flag bits answer with one invalid-command status byte
            st0_d = {IC_INVALID, 6'h00};
            rlen_d = RES_LEN_BAD;
            st_d = FDCRV_RESULT;
          end
        end
      FDCRV_CMD:
        if (cmd_wr_i) // [RULE13]
        begin
          if (pcnt_q == 4'h1)
          begin
            hds_d = cmd_sel[BIT_HEAD];
            ds_d  = cmd_sel[1:0];
            ec_d  = (op_q == OP_VERIFY) && cmd_sel[BIT_COUNT_EN]; // [RULE6]
          end
          else
            par_d[3'(pcnt_q - 4'h2)] = cmd_sel;
          pcnt_d = pcnt_q + 4'h1;
          if (pcnt_q == plast_q)
          begin
            st_d = FDCRV_SEEK; idx_d = 2'h0; seen_d = 1'b0;
            scnt_d = 8'h00; rlen_d = RES_LEN;
          end
        end
      FDCRV_SEEK:
        if (idx_e)
        begin
          seen_d = 1'b1;
          idx_d = idx_q + 2'h1;
          // A second index pulse without a usable sector ends the command
          if (idx_q == IDX_LIMIT - 2'h1)
          begin
            fail = 1'b1;
            st1_d = (op_q == OP_READ_ID) ? ST1_MISS_AM : ST1_NO_DATA;
          end
        end
        else if (id_e)
        begin
          if (op_q == OP_READ_ID)
          begin
            if (id_ok) // [RULE4]
            begin
              par_d[P_C] = id_c; par_d[P_H] = id_h;
              par_d[P_R] = id_r; par_d[P_N] = id_n;
              done = 1'b1; // [RULE5]
            end
          end
          else if (op_q == OP_READ_TRACK)
          begin
            if (seen_q) // [RULE2]
            begin
              par_d[P_R] = id_r;
              if (!id_ok)
                st1_d = st1_q | ST1_CRC_ERR;
              cnt_if.start = 1'b1;
              st_d = FDCRV_XFER;
            end
          end
          else if (id_c == par_q[P_C] && id_h == par_q[P_H] &&
                   id_r == par_q[P_R])
          begin
            if (!id_ok)
            begin
              fail = 1'b1;
              st1_d = ST1_CRC_ERR;
            end
            else if (id_del && sk_q && op_q == OP_VERIFY)
              adv = 1'b1; // [RULE10]
            else
            begin
              if (id_del)
                st2_d = st2_q | ST2_DEL_MARK;
              cnt_if.start = 1'b1;
              st_d = FDCRV_XFER;
            end
          end
        end
      FDCRV_XFER:
        if (is_rd)
        begin
          if (rd_e && op_q == OP_READ_TRACK)
          begin
            hv_d = 1'b1; // [RULE2]
            hb_d = rd_byte;
          end
          // Verify only counts bytes past the head, none reach the host
          if (cnt_if.last) // [RULE7]
            adv = 1'b1;
        end
        else
        begin
          req_d = 1'b1;
          if (host_byte_valid_i && req_q) // [RULE9]
          begin
            dv_d = 1'b1;
            db_d = host_byte_i;
            if (cnt_if.last)
            begin
              req_d = 1'b0;
              adv = 1'b1;
            end
          end
        end
      FDCRV_RESULT:
        if (res_rd_i) // [RULE13]
        begin
          ptr_d = ptr_q + 3'h1;
          if (ptr_q == rlen_q - 3'h1)
            st_d = FDCRV_IDLE;
        end
      default:
        st_d = FDCRV_IDLE;
    endcase

    if (adv)
    begin
      scnt_d = scnt_q + 8'h01;
      st_d = FDCRV_SEEK;
      idx_d = 2'h0;
      if (op_q == OP_READ_TRACK)
        done = (scnt_q + 8'h01 == par_q[P_EOT]); // [RULE2]
      else if (op_q == OP_VERIFY && ec_q &&
               scnt_q + 8'h01 == par_q[P_DTL]) // [RULE12]
        done = 1'b1;
      else if (par_q[P_R] == par_q[P_EOT] && mt_q && !hds_q)
      begin
        hds_d = 1'b1;
        par_d[P_H] = 8'h01;
        par_d[P_R] = 8'h01;
      end
      else if (par_q[P_R] == par_q[P_EOT])
      begin
        par_d[P_R] = 8'h01;
        par_d[P_C] = par_q[P_C] + 8'h01;
        done = 1'b1;
      end
      else
        par_d[P_R] = par_q[P_R] + 8'h01;
    end
    if (done || fail)
    begin
      st0_d = mk_st0(fail ? IC_ABNORMAL : IC_NORMAL, hds_d, ds_q);
      st_d = FDCRV_RESULT; // [RULE3] [RULE8] [RULE9]
      ptr_d = 3'h0;
    end

    // Order: three status bytes, then cylinder, head, record, size
    case (ptr_d)
      3'h0:    res_d = st0_d;
      3'h1:    res_d = st1_d;
      3'h2:    res_d = st2_d;
      3'h3:    res_d = par_d[P_C];
      3'h4:    res_d = par_d[P_H];
      3'h5:    res_d = par_d[P_R];
      3'h6:    res_d = par_d[P_N];
      default: res_d = 8'h00;
    endcase
    if (st_d != FDCRV_RESULT)
      res_d = 8'h00;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= FDCRV_IDLE; op_q <= 5'h00; mt_q <= 1'b0; sk_q <= 1'b0;
      ec_q <= 1'b0; mfm_q <= 1'b0; hds_q <= 1'b0; ds_q <= 2'h0;
      seen_q <= 1'b0; idx_q <= 2'h0; pcnt_q <= 4'h0; plast_q <= 4'h0;
      ptr_q <= 3'h0; rlen_q <= 3'h0; st0_q <= 8'h00; st1_q <= 8'h00;
      st2_q <= 8'h00; scnt_q <= 8'h00; res_q <= 8'h00; hb_q <= 8'h00;
      db_q <= 8'h00; hv_q <= 1'b0; dv_q <= 1'b0; req_q <= 1'b0;
      par_q <= '{default: 8'h00};
    end
    else
    begin
      st_q <= st_d; op_q <= op_d; mt_q <= mt_d; sk_q <= sk_d;
      ec_q <= ec_d; mfm_q <= mfm_d; hds_q <= hds_d; ds_q <= ds_d;
      seen_q <= seen_d; idx_q <= idx_d; pcnt_q <= pcnt_d;
      plast_q <= plast_d; ptr_q <= ptr_d; rlen_q <= rlen_d;
      st0_q <= st0_d; st1_q <= st1_d; st2_q <= st2_d; scnt_q <= scnt_d;
      res_q <= res_d; hb_q <= hb_d; db_q <= db_d; hv_q <= hv_d;
      dv_q <= dv_d; req_q <= req_d; par_q <= par_d;
    end
  end

  logic busy_q;
  logic rv_q;
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_q <= 1'b0;
      rv_q   <= 1'b0;
    end
    else
    begin
      busy_q <= (st_d == FDCRV_SEEK) || (st_d == FDCRV_XFER);
      rv_q   <= (st_d == FDCRV_RESULT);
    end
  end

  assign busy_o            = busy_q;
  assign res_valid_o       = rv_q;
  assign res_data_o        = res_q;
  assign host_byte_valid_o = hv_q;
  assign host_byte_o       = hb_q;
  assign data_req_o        = req_q;
  assign disk_byte_valid_o = dv_q;
  assign disk_byte_o       = db_q;
  assign drive_sel_o       = ds_q;
  assign head_sel_o        = hds_q;
  assign density_o         = mfm_q;
endmodule : fdcrv_top

// file: sim/fdcrv_chk.sv
// Checker of decode, phase and transfer relations at the top ports
`timescale 1ns/1ps
module fdcrv_chk
  import fdcrv_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cmd_wr_i,
  input wire logic [7:0] cmd_byte_i,
  input wire logic       host_byte_valid_i,
  input wire logic [7:0] host_byte_i,
  input wire logic       busy_o,
  input wire logic       res_valid_o,
  input wire logic [7:0] res_data_o,
  input wire logic       host_byte_valid_o,
  input wire logic       data_req_o,
  input wire logic       disk_byte_valid_o,
  input wire logic [7:0] disk_byte_o,
  input wire logic [1:0] drive_sel_o,
  input wire logic       head_sel_o,
  input wire logic       density_o
);
  logic [7:0] op_q;
  logic [7:0] op_d;
  logic [7:0] sel_q;
  logic [7:0] sel_d;
  logic [3:0] idx_q;
  logic [3:0] idx_d;
  logic       idle;
  logic       bad_op;
  assign idle = !busy_o && !res_valid_o;
  always_comb
  begin
    op_d  = op_q;
    sel_d = sel_q;
    idx_d = idle ? idx_q : 4'h0;
    if (cmd_wr_i && idle)
    begin
      idx_d = idx_q + 4'h1;
      if (idx_q == 4'h0)
        op_d = cmd_byte_i;
      if (idx_q == 4'h1)
        sel_d = cmd_byte_i;
    end
  end
  always_comb
  begin
    case (cmd_byte_i[4:0])
      OP_READ_TRACK: bad_op = cmd_byte_i[7:5] != 3'h0;
      OP_READ_ID:    bad_op = cmd_byte_i[7];
      OP_VERIFY:     bad_op = 1'b0;
      OP_WRITE:      bad_op = cmd_byte_i[5];
      default:       bad_op = 1'b1;
    endcase
  end
  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      op_q  <= 8'h00;
      sel_q <= 8'h00;
      idx_q <= 4'h0;
    end
    else
    begin
      op_q  <= op_d;
      sel_q <= sel_d;
      idx_q <= idx_d;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  bad_op_a: assert property (
    cmd_wr_i && idle && idx_q == 4'h0 && bad_op
    |=> res_valid_o && res_data_o == 8'h80) else $error("bad opcode");
  id_start_a: assert property (
    cmd_wr_i && idle && idx_q == 4'h1 && op_q[4:0] == OP_READ_ID
    |=> busy_o) else $error("read id start");
  rw_start_a: assert property (
    cmd_wr_i && idle && idx_q == 4'h8 |=> busy_o)
    else $error("nine byte start");
  sel_out_a: assert property (
    $rose(busy_o) |-> drive_sel_o == sel_q[1:0]
    && head_sel_o == sel_q[BIT_HEAD] && density_o == op_q[BIT_DENSITY])
    else $error("select outputs");
  verify_quiet_a: assert property (
    busy_o && op_q[4:0] == OP_VERIFY
    |-> !host_byte_valid_o && !disk_byte_valid_o && !data_req_o)
    else $error("verify moved data");
  track_only_a: assert property (
    host_byte_valid_o |-> op_q[4:0] == OP_READ_TRACK)
    else $error("host data outside track read");
  write_pass_a: assert property (
    host_byte_valid_i && data_req_o
    |=> disk_byte_valid_o && disk_byte_o == $past(host_byte_i))
    else $error("write byte lost");
  res_quiet_a: assert property (
    !res_valid_o |-> res_data_o == 8'h00) else $error("result leak");
  st0_sel_a: assert property (
    $rose(res_valid_o) && $past(busy_o)
    |-> res_data_o[2:0] == {head_sel_o, sel_q[1:0]})
    else $error("status select");
endmodule : fdcrv_chk

// file: sim/fdcrv_drive_model.sv
// Behavioural drive: index, sector IDs and read data per rotation
`timescale 1ns/1ps
module fdcrv_drive_model
#(
  parameter int NSEC = 4,
  parameter int DATA_LENGTH  = 4
)
(
  input  wire logic       clk_i,
  input  wire logic [7:0] cyl_i,
  input  wire logic [7:0] crc_bad_i,
  input  wire logic [7:0] del_i,
  output logic            index_o,
  output logic            id_stb_o,
  output logic            crc_ok_o,
  output logic            del_o,
  output logic [7:0]      c_o,
  output logic [7:0]      r_o,
  output logic            rd_stb_o,
  output logic [7:0]      rd_o
);
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hold
  initial
  begin
    {index_o, id_stb_o, rd_stb_o, crc_ok_o, del_o} = 5'h00;
    {c_o, r_o, rd_o} = 24'h000000;
    hold(1);
    forever
    begin
      index_o <= 1'b1;
      hold(3);
      index_o <= 1'b0;
      hold(4);
      for (int r = 1; r <= NSEC; r++)
      begin
        c_o      <= cyl_i;
        r_o      <= 8'(r);
        crc_ok_o <= !crc_bad_i[r];
        del_o    <= del_i[r];
        hold(1);
        id_stb_o <= 1'b1;
        hold(4);
        id_stb_o <= 1'b0;
        // Stale ID must not be reused
        c_o      <= ~c_o;
        r_o      <= ~r_o;
        hold(3);
        for (int k = 0; k < DATA_LENGTH; k++)
        begin
          rd_o     <= {r[3:0], k[3:0]};
          hold(1);
          rd_stb_o <= 1'b1;
          hold(4);
          rd_stb_o <= 1'b0;
          rd_o     <= ~rd_o;
          hold(3);
        end
      end
    end
  end
endmodule : fdcrv_drive_model

// file: sim/testbench.sv
// Self-checking bench for the command sequencer
`timescale 1ns/1ps
module testbench;
  typedef logic [7:0] fdcrv_bq_t [$];
  typedef logic [8:0] fdcrv_eq_t [$];
  logic       core_clk_i = 1'b0;
  logic       sys_rst_i  = 1'b1;
  logic       cmd_wr_i   = 1'b0;
  logic [7:0] cmd_byte_i = 8'h00;
  logic       res_rd_i   = 1'b0;
  logic       hv         = 1'b0;
  logic [7:0] hb         = 8'h00;
  logic [7:0] cyl        = 8'h00;
  logic [7:0] crc_bad    = 8'h00;
  logic [7:0] del        = 8'h00;
  logic       idx, ids, cok, dl, rs, busy, rv, hov, drq, dov, hsel, dens;
  logic [7:0] ic, ir, rb, rdat, ho, dob, c1;
  logic [1:0] dsel;
  logic [8:0] e;
  logic [7:0] badop [4] = '{8'h82, 8'h8a, 8'h25, 8'h1f};
  int         bad_count   = 0;
  int         checks_done = 0;
  int         cyc         = 0;
  fdcrv_eq_t  rq;
  fdcrv_bq_t  hq;
  fdcrv_bq_t  dq;
  fdcrv_top u_fdcrv_top (.core_clk_i, .sys_rst_i, .cmd_wr_i, .cmd_byte_i,
    .res_rd_i, .host_byte_valid_i(hv), .host_byte_i(hb), .index_pin_i(idx),
    .id_stb_pin_i(ids), .id_crc_ok_pin_i(cok), .id_deleted_pin_i(dl),
    .id_c_pin_i(ic), .id_h_pin_i({7'h00, hsel}), .id_r_pin_i(ir),
    .id_n_pin_i(8'h00), .rd_stb_pin_i(rs), .rd_byte_pin_i(rb),
    .busy_o(busy), .res_valid_o(rv), .res_data_o(rdat),
    .host_byte_valid_o(hov), .host_byte_o(ho), .data_req_o(drq),
    .disk_byte_valid_o(dov), .disk_byte_o(dob), .drive_sel_o(dsel),
    .head_sel_o(hsel), .density_o(dens));
  fdcrv_drive_model u_fdcrv_drive_model (.clk_i(core_clk_i), .cyl_i(cyl),
    .crc_bad_i(crc_bad), .del_i(del), .index_o(idx), .id_stb_o(ids),
    .crc_ok_o(cok), .del_o(dl), .c_o(ic), .r_o(ir), .rd_stb_o(rs),
    .rd_o(rb));
  initial
    forever #10 core_clk_i = ~core_clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Host sends all bytes, then results drain via the monitor
  task automatic run(input string nm, input fdcrv_bq_t b,
                     input fdcrv_eq_t x);
    int n;
    rq = x;
    foreach (b[i])
    begin
      @(negedge core_clk_i);
      cmd_wr_i   = 1'b1;
      cmd_byte_i = b[i];
    end
    @(negedge core_clk_i);
    cmd_wr_i = 1'b0;
    n = 0;
    while ((rq.size() > 0 || rv !== 1'b0) && n < 3000)
    begin
      @(negedge core_clk_i);
      n++;
    end
    if (n == 3000)
      bad_count++;
    check(8'(hq.size() + dq.size()), 8'h00);
    $display("test %s done", nm);
  endtask : run
  always @(negedge core_clk_i)
  begin
    hv = (drq === 1'b1);
    hb = 8'($urandom);
    if (hv)
      dq.push_back(hb);
  end
  always @(negedge core_clk_i)
  begin
    if (res_rd_i)
      res_rd_i = 1'b0;
    else if (rv === 1'b1)
    begin
      e = (rq.size() > 0) ? rq.pop_front() : 9'h1ff;
      if (e[8])
        check(rdat, e[7:0]);
      res_rd_i = 1'b1;
    end
    if (hov === 1'b1)
      check(ho, (hq.size() > 0) ? hq.pop_front() : ~ho);
    if (dov === 1'b1)
      check(dob, (dq.size() > 0) ? dq.pop_front() : ~dob);
  end
  always @(posedge core_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      end_sim();
    end
  end
  initial
  begin
    void'($urandom(32'h6cfe03ac));
    cyl = 8'($urandom_range(126, 0));
    c1  = cyl + 8'h01;
    repeat (20) @(negedge core_clk_i);
    // Set long before the ID read so no ID latched earlier is stale
    crc_bad = 8'hfb;
    sys_rst_i = 1'b0;
    foreach (badop[i])
      run("invalid", '{badop[i]}, '{9'h180});
    run("read id", '{8'h4a, 8'h01}, '{9'h101, 9'h100, 9'h100, {1'b1, cyl},
        9'h100, 9'h102, 9'h100});
    crc_bad = 8'h00;
    for (int r = 1; r <= 4; r++)
      for (int k = 0; k < 4; k++)
        hq.push_back({r[3:0], k[3:0]});
    run("track", '{8'h02, 8'h04, cyl, 8'h00, 8'h01, 8'h00, 8'h04, 8'h1b,
        8'h04}, '{9'h104, 9'h100, 9'h100, {1'b1, cyl}, 9'h100, 9'h104,
        9'h100});
    run("verify count", '{8'h56, 8'h80, cyl, 8'h00, 8'h01, 8'h00, 8'h04,
        8'h1b, 8'h02}, '{9'h100, 9'h100, 9'h100, {1'b1, cyl}, 9'h100,
        9'h102, 9'h100});
    del = 8'h04;
    run("verify skip", '{8'h36, 8'h00, cyl, 8'h00, 8'h02, 8'h00, 8'h03,
        8'h1b, 8'h04}, '{9'h100, 9'h100, 9'h100, {1'b1, c1}, 9'h100,
        9'h101, 9'h100});
    del = 8'h00;
    run("write", '{8'h45, 8'h00, cyl, 8'h00, 8'h04, 8'h01, 8'h04, 8'h1b,
        8'h04}, '{9'h100, 9'h100, 9'h100, {1'b1, c1}, 9'h100, 9'h101,
        9'h101});
    // Multitrack: sector 4 on head 0, then sectors 1 to 4 on head 1
    run("write mt", '{8'hc5, 8'h01, cyl, 8'h00, 8'h04, 8'h00, 8'h04, 8'h1b,
        8'h02}, '{9'h105, 9'h100, 9'h100, {1'b1, c1}, 9'h101, 9'h101,
        9'h100});
    end_sim();
  end
endmodule : testbench
bind fdcrv_top fdcrv_chk u_fdcrv_chk (.core_clk_i, .sys_rst_i, .cmd_wr_i,
  .cmd_byte_i, .host_byte_valid_i, .host_byte_i, .busy_o, .res_valid_o,
  .res_data_o, .host_byte_valid_o, .data_req_o, .disk_byte_valid_o,
  .disk_byte_o, .drive_sel_o, .head_sel_o, .density_o);
